// ==== core/lsp_map.svh ====
// Constants for the lane sample packer: modes, widths, lane sizes.
// Included by the package and the design modules; definitions only.
`ifndef LSP_MAP_SVH
`define LSP_MAP_SVH

// Link format modes handled here
`define LSP_MODE3    4'h3
`define LSP_MODE4    4'h4
`define LSP_MODE5    4'h5
`define LSP_MODE6    4'h6
`define LSP_MODE7    4'h7
`define LSP_MODE8    4'h8
`define LSP_MODE9    4'h9

// Geometry
`define LSP_SAMP_W   12
`define LSP_CHANS    4
`define LSP_DEPTH    4
`define LSP_LANES    8
`define LSP_WORD_W   40

// Bits per lane per frame
`define LSP_BITS_40  6'h28
`define LSP_BITS_24  6'h18
`define LSP_BITS_16  6'h10
`define LSP_BITS_8   6'h08

`endif

// ==== core/lsp_pkg.sv ====
// Types and shared decoders of the lane sample packer.
// Assumes lsp_map.svh is on the include path.
`include "lsp_map.svh"

package lsp_pkg;

    typedef enum logic [1:0] {LSP_QUAD, LSP_DUAL, LSP_SINGLE} lsp_chan_e;
    typedef logic [`LSP_SAMP_W-1:0] lsp_samp_t;
    typedef logic [3:0]             lsp_mode_t;

    // Samples per channel gathered into one frame; zero: mode unsupported
    function automatic logic [2:0] lsp_depth(input lsp_mode_t mode);
        case (mode)
            `LSP_MODE3:                         lsp_depth = 3'h4;
            `LSP_MODE6, `LSP_MODE8, `LSP_MODE9: lsp_depth = 3'h2;
            `LSP_MODE4, `LSP_MODE5, `LSP_MODE7: lsp_depth = 3'h1;
            default:                            lsp_depth = 3'h0;
        endcase
    endfunction

    // Lanes in use: quad, dual, single columns
    function automatic logic [3:0] lsp_lane_cnt(input lsp_mode_t mode,
                                                input lsp_chan_e chans);
        logic [11:0] row;
        case (mode)
            `LSP_MODE3: row = 12'h421;
            `LSP_MODE4: row = 12'h321;
            `LSP_MODE5: row = 12'h211;
            `LSP_MODE6: row = 12'h632;
            `LSP_MODE7: row = 12'h421;
            `LSP_MODE8: row = 12'h421;
            `LSP_MODE9: row = 12'h842;
            default:    row = 12'h000;
        endcase
        case (chans)
            LSP_QUAD:   lsp_lane_cnt = row[11:8];
            LSP_DUAL:   lsp_lane_cnt = row[7:4];
            default:    lsp_lane_cnt = row[3:0];
        endcase
    endfunction

    function automatic logic [5:0] lsp_lane_bits(input lsp_mode_t mode);
        case (mode)
            `LSP_MODE3:                         lsp_lane_bits = `LSP_BITS_40;
            `LSP_MODE8:                         lsp_lane_bits = `LSP_BITS_24;
            `LSP_MODE4, `LSP_MODE5, `LSP_MODE6: lsp_lane_bits = `LSP_BITS_16;
            `LSP_MODE7, `LSP_MODE9:             lsp_lane_bits = `LSP_BITS_8;
            default:                            lsp_lane_bits = 6'h00;
        endcase
    endfunction

endpackage

// ==== core/lsp_frame_if.sv ====
// Carries one gathered frame of samples from gatherer to packer.
// Both ends run on core_clk.
`timescale 1ns/1ns
`include "lsp_map.svh"

interface lsp_frame_if;
    logic                 frame_valid;
    lsp_pkg::lsp_mode_t   mode;
    lsp_pkg::lsp_chan_e   chans;
    // Indexed [channel][sample number]
    lsp_pkg::lsp_samp_t [`LSP_CHANS-1:0][`LSP_DEPTH-1:0] samp;

    modport gather (output frame_valid, mode, chans, samp);
    modport pack   (input  frame_valid, mode, chans, samp);
endinterface

// ==== core/lsp_gather.sv ====
// Collects successive samples of channels A..D into one frame.
// Assumes mode and channel setting are static while streaming.
`timescale 1ns/1ns
`include "lsp_map.svh"

module lsp_gather (
    // Clock and reset
    input  wire logic                 core_clk,
    input  wire logic                 sys_rst,
    // Configuration
    input  wire lsp_pkg::lsp_mode_t   link_format_mode,
    input  wire lsp_pkg::lsp_chan_e   chan_cfg,
    // Sample input, one per channel per strobe
    input  wire logic                 samp_valid,
    input  wire lsp_pkg::lsp_samp_t [`LSP_CHANS-1:0] samp_in,
    // Frame out
    lsp_frame_if.gather               frm
);

    logic [2:0]          depth;
    logic [1:0]          idx_reg,   idx_next;
    logic                fv_reg,    fv_next;
    lsp_pkg::lsp_mode_t  mode_reg,  mode_next;
    lsp_pkg::lsp_chan_e  chans_reg, chans_next;
    lsp_pkg::lsp_samp_t [`LSP_CHANS-1:0][`LSP_DEPTH-1:0] buf_reg, buf_next;

    assign depth = lsp_pkg::lsp_depth(link_format_mode);

    ////////////////////////////////////////////////////////////////////////
    // sampling order kept
    always_comb begin
        idx_next   = idx_reg;
        fv_next    = 1'b0;
        mode_next  = link_format_mode;
        chans_next = chan_cfg;
        buf_next   = buf_reg;
        // Config change restarts the frame so no mixed-mode frame leaks out
        if (link_format_mode != mode_reg || chan_cfg != chans_reg) begin
            idx_next = 2'h0;
        end else if (samp_valid && depth != 3'h0) begin
            for (int c = 0; c < `LSP_CHANS; c++) begin
                buf_next[c][idx_reg] = samp_in[c];
            end
            if ({1'b0, idx_reg} == depth - 3'h1) begin
                idx_next = 2'h0;
                fv_next  = 1'b1;
            end else begin
                idx_next = idx_reg + 2'h1;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            idx_reg   <= 2'h0;
            fv_reg    <= 1'b0;
            mode_reg  <= 4'h0;
            chans_reg <= lsp_pkg::LSP_QUAD;
            buf_reg   <= '0;
        end else begin
            idx_reg   <= idx_next;
            fv_reg    <= fv_next;
            mode_reg  <= mode_next;
            chans_reg <= chans_next;
            buf_reg   <= buf_next;
        end
    end

    assign frm.frame_valid = fv_reg;
    assign frm.mode        = mode_reg;
    assign frm.chans       = chans_reg;
    assign frm.samp        = buf_reg;

    ////////////////////////////////////////////////////////////////////////
    sequence s_last_sample;
        samp_valid && depth != 3'h0 && link_format_mode == mode_reg
            && chan_cfg == chans_reg && {1'b0, idx_reg} == depth - 3'h1;
    endsequence

    a_frame_on_last: assert property (@(posedge core_clk) disable iff (sys_rst)
        s_last_sample |=> fv_reg && frm.samp[0][$past(idx_reg)] ==
            $past(samp_in[0]))
        else $error("frame not issued after last sample");

    a_bad_mode_idle: assert property (@(posedge core_clk) disable iff (sys_rst)
        depth == 3'h0 |=> !fv_reg)
        else $error("frame issued in unsupported mode");

endmodule // lsp_gather

// ==== core/lsp_packer.sv ====
// Lane sample packer: gathers converter samples and maps them onto up
// to eight lane words per frame. Link coding and sync sit downstream;
// the downstream end takes each lane word, MSB first, on out_valid.
`timescale 1ns/1ns
`include "lsp_map.svh"

// Function
// - Mode 3: 10-bit, 4/2/1 lanes, one channel per lane, four samples
// - Mode 4: 12-bit samples over 3/2/1 lanes
// - Mode 4: A0, then B0 split across lanes, C0 split, zero pads
// - Mode 5: 8-bit, lane 0 A then B or zero, lane 1 C D
// - Mode 6: triple packs A0 A1 B0 B1, zero octet when single
// - Mode 7: 8-bit, one sample per lane, lanes 0-3 channels A-D
// - Mode 8: two 12-bit samples per lane in three octets
// - Mode 9: two lanes per channel, even then odd sample
// - Sample index n is the nth sample of that channel in order
module lsp_packer (
    // Clock and reset
    input  wire logic                 core_clk,
    input  wire logic                 sys_rst,
    // Configuration
    input  wire lsp_pkg::lsp_mode_t   link_format_mode,
    input  wire lsp_pkg::lsp_chan_e   chan_cfg,
    // Samples, right justified, [0]=A .. [3]=D
    input  wire logic                 samp_valid,
    input  wire lsp_pkg::lsp_samp_t [`LSP_CHANS-1:0] samp_in,
    // Lane words, left justified
    output logic                      out_valid,
    output logic [`LSP_LANES-1:0]     lane_en,
    output logic [5:0]                lane_bits,
    output logic [`LSP_LANES-1:0][`LSP_WORD_W-1:0] lane_word
);

    lsp_frame_if frm ();

    lsp_gather u_gather (
        .core_clk         (core_clk),
        .sys_rst          (sys_rst),
        .link_format_mode (link_format_mode),
        .chan_cfg         (chan_cfg),
        .samp_valid       (samp_valid),
        .samp_in          (samp_in),
        .frm              (frm)
    );

    logic                             ov_reg,   ov_next;
    logic [`LSP_LANES-1:0]            en_reg,   en_next;
    logic [5:0]                       bits_reg, bits_next;
    logic [`LSP_LANES-1:0][`LSP_WORD_W-1:0] word_reg, word_next;
    lsp_pkg::lsp_mode_t               mode_reg, mode_next;
    lsp_pkg::lsp_chan_e               ch_reg,   ch_next;
    logic [3:0]                       cnt;
    logic                             single;
    logic                             quad;

    assign cnt    = lsp_pkg::lsp_lane_cnt(frm.mode, frm.chans);
    assign single = frm.chans == lsp_pkg::LSP_SINGLE;
    assign quad   = frm.chans == lsp_pkg::LSP_QUAD;

    ////////////////////////////////////////////////////////////////////////
    // Packing
    always_comb begin
        ov_next   = 1'b0;
        en_next   = en_reg;
        bits_next = bits_reg;
        word_next = word_reg;
        mode_next = mode_reg;
        ch_next   = ch_reg;
        if (frm.frame_valid) begin
            ov_next   = 1'b1;
            mode_next = frm.mode;
            ch_next   = frm.chans;
            bits_next = lsp_pkg::lsp_lane_bits(frm.mode);
            word_next = '0;
            for (int l = 0; l < `LSP_LANES; l++) begin
                en_next[l] = l < int'(cnt);
            end
            case (frm.mode)
                `LSP_MODE3: begin
                    for (int c = 0; c < `LSP_CHANS; c++) begin
                        word_next[c] = {frm.samp[c][0][9:0],
                                        frm.samp[c][1][9:0],
                                        frm.samp[c][2][9:0],
                                        frm.samp[c][3][9:0]};
                    end
                end
                `LSP_MODE4: begin
                    // A0 B0 C0 D0 over three lanes
                    word_next[0][39:24] = {frm.samp[0][0],
                        single ? 4'h0 : frm.samp[1][0][11:8]};
                    word_next[1][39:24] = {frm.samp[1][0][7:0],
                        quad ? frm.samp[2][0][11:4] : 8'h00};
                    word_next[2][39:24] = {frm.samp[2][0][3:0],
                                           frm.samp[3][0]};
                end
                `LSP_MODE5: begin
                    word_next[0][39:24] = {frm.samp[0][0][7:0],
                        single ? 8'h00 : frm.samp[1][0][7:0]};
                    word_next[1][39:24] = {frm.samp[2][0][7:0],
                                           frm.samp[3][0][7:0]};
                end
                `LSP_MODE6: begin
                    for (int p = 0; p < 2; p++) begin
                        word_next[3*p][39:24] = {frm.samp[2*p][0],
                            frm.samp[2*p][1][11:8]};
                        word_next[3*p+1][39:24] = {frm.samp[2*p][1][7:0],
                            single ? 8'h00 : frm.samp[2*p+1][0][11:4]};
                        word_next[3*p+2][39:24] =
                            {frm.samp[2*p+1][0][3:0], frm.samp[2*p+1][1]};
                    end
                end
                `LSP_MODE7: begin
                    for (int c = 0; c < `LSP_CHANS; c++) begin
                        word_next[c][39:32] = frm.samp[c][0][7:0];
                    end
                end
                `LSP_MODE8: begin
                    // two 12-bit samples in three octets
                    for (int c = 0; c < `LSP_CHANS; c++) begin
                        word_next[c][39:16] = {frm.samp[c][0],
                                               frm.samp[c][1]};
                    end
                end
                `LSP_MODE9: begin
                    // even sample lane, then odd sample lane
                    for (int c = 0; c < `LSP_CHANS; c++) begin
                        word_next[2*c][39:32]   = frm.samp[c][0][7:0];
                        word_next[2*c+1][39:32] = frm.samp[c][1][7:0];
                    end
                end
                default: begin
                    word_next = '0;
                end
            endcase
            for (int l = 0; l < `LSP_LANES; l++) begin
                if (!en_next[l]) begin
                    word_next[l] = '0;
                end
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            ov_reg   <= 1'b0;
            en_reg   <= '0;
            bits_reg <= 6'h00;
            word_reg <= '0;
            mode_reg <= 4'h0;
            ch_reg   <= lsp_pkg::LSP_QUAD;
        end else begin
            ov_reg   <= ov_next;
            en_reg   <= en_next;
            bits_reg <= bits_next;
            word_reg <= word_next;
            mode_reg <= mode_next;
            ch_reg   <= ch_next;
        end
    end

    assign out_valid = ov_reg;
    assign lane_en   = en_reg;
    assign lane_bits = bits_reg;
    assign lane_word = word_reg;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    sequence s_frame;
        frm.frame_valid;
    endsequence

    // Back to back frames keep out_valid up, so only a gap may drop it
    a_out_follows: assert property (s_frame |=> ov_reg ##1
        (ov_reg == $past(frm.frame_valid)))
        else $error("output did not follow frame by one cycle");

    a_mode3_lane: assert property (ov_reg && mode_reg == `LSP_MODE3 |->
        word_reg[0][39:30] == $past(frm.samp[0][0][9:0]) &&
        word_reg[0][9:0] == $past(frm.samp[0][3][9:0]) &&
        bits_reg == `LSP_BITS_40)
        else $error("mode 3 lane 0 packing wrong");

    a_mode4_count: assert property (ov_reg && mode_reg == `LSP_MODE4 &&
        ch_reg == lsp_pkg::LSP_QUAD |-> en_reg == 8'h07)
        else $error("mode 4 quad lane count wrong");

    a_mode4_pad: assert property (ov_reg && mode_reg == `LSP_MODE4 &&
        ch_reg == lsp_pkg::LSP_SINGLE |->
        word_reg[0][27:24] == 4'h0 && en_reg == 8'h01)
        else $error("mode 4 single pad wrong");

    a_mode5_quad: assert property (ov_reg && mode_reg == `LSP_MODE5 &&
        ch_reg == lsp_pkg::LSP_QUAD |->
        word_reg[1][39:32] == $past(frm.samp[2][0][7:0]))
        else $error("mode 5 lane 1 wrong");

    a_mode6_first: assert property (ov_reg && mode_reg == `LSP_MODE6 |->
        word_reg[0][39:28] == $past(frm.samp[0][0]))
        else $error("mode 6 lane 0 wrong");

    a_mode6_pair2: assert property (ov_reg && mode_reg == `LSP_MODE6 &&
        ch_reg == lsp_pkg::LSP_QUAD |->
        word_reg[5][35:24] == $past(frm.samp[3][1]))
        else $error("mode 6 lane 5 wrong");

    a_mode7_width: assert property (ov_reg && mode_reg == `LSP_MODE7 |->
        bits_reg == `LSP_BITS_8 &&
        word_reg[0][39:32] == $past(frm.samp[0][0][7:0]))
        else $error("mode 7 lane wrong");

    a_mode8_pair: assert property (ov_reg && mode_reg == `LSP_MODE8 |->
        word_reg[0][27:16] == $past(frm.samp[0][1]))
        else $error("mode 8 second sample wrong");

    a_mode9_odd: assert property (ov_reg && mode_reg == `LSP_MODE9 |->
        word_reg[1][39:32] == $past(frm.samp[0][1][7:0]))
        else $error("mode 9 odd lane wrong");

    a_unused_zero: assert property (ov_reg && !en_reg[7] |->
        word_reg[7] == '0)
        else $error("unused lane not zero");

endmodule // lsp_packer

// ==== dv/lsp_link_rx.sv ====
// Link receiver model: keeps every frame of lane words the packer sends.
// Assumes out_valid is a one-cycle strobe on core_clk per frame.
`timescale 1ns/1ns

module lsp_link_rx (
    // Clock
    input wire logic             core_clk,
    // Lane words from the packer
    input wire logic             out_valid,
    input wire logic [7:0]       lane_en,
    input wire logic [5:0]       lane_bits,
    input wire logic [7:0][39:0] lane_word
);
    typedef struct packed {
        logic [7:0]       en;
        logic [5:0]       bits;
        logic [7:0][39:0] word;
    } lsp_frm_s;

    lsp_frm_s frames [$];
    lsp_frm_s f;

    ////////////////////////////////////////////////////////////////////////
    // lane words read MSB first
    // Only the top lane_bits of an enabled lane reach the deframer;
    // anything below or on an idle lane is never looked at.
    always @(posedge core_clk) begin
        if (out_valid === 1'b1) begin
            f.en = lane_en;
            f.bits = lane_bits;
            for (int i = 0; i < 8; i++) begin
                f.word[i] = lane_en[i] ? lane_word[i] &
                    ~((40'h1 << (40 - lane_bits)) - 40'h1) : 40'h0;
            end
            frames.push_back(f);
        end
    end
endmodule // lsp_link_rx

// ==== dv/lane_sample_packer_tb_top.sv ====
// Self-checking bench of the lane sample packer with a receiver model.
// Assumes lsp_map.svh on the include path and a 50 MHz core_clk.
`timescale 1ns/1ns

module lane_sample_packer_tb_top;
    typedef struct packed {
        logic [7:0]       en;
        logic [5:0]       bits;
        logic [7:0][39:0] word;
    } lsp_frm_s;

    logic                     core_clk = 1'b0;
    logic                     sys_rst = 1'b1;
    lsp_pkg::lsp_mode_t       mode = 4'h0;
    lsp_pkg::lsp_chan_e       chans = lsp_pkg::LSP_QUAD;
    logic                     samp_valid = 1'b0;
    lsp_pkg::lsp_samp_t [3:0] samp_in = '0;
    logic                     out_valid;
    logic [7:0]               lane_en;
    logic [5:0]               lane_bits;
    logic [7:0][39:0]         lane_word;
    logic [11:0]              smp [4][4];
    lsp_frm_s                 exp_q [$];
    int                       n_fail = 0;
    int                       checks_done = 0;
    int                       base = 0;

    always #10 core_clk = ~core_clk;

    lsp_packer dut (.core_clk(core_clk), .sys_rst(sys_rst),
        .link_format_mode(mode), .chan_cfg(chans), .samp_valid(samp_valid),
        .samp_in(samp_in), .out_valid(out_valid), .lane_en(lane_en),
        .lane_bits(lane_bits), .lane_word(lane_word));

    lsp_link_rx rx (.core_clk(core_clk), .out_valid(out_valid),
        .lane_en(lane_en), .lane_bits(lane_bits), .lane_word(lane_word));

    ////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        $display("checks %0d failures %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input logic [333:0] got, input logic [333:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // Inputs always move 2 ns after the rising edge
    task automatic step(input int n);
        repeat (n) begin
            @(posedge core_clk);
            #2;
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    function automatic int lanes(input lsp_pkg::lsp_mode_t m, input int nch);
        int q, d, s;
        case (m)
            4'h4: begin q = 3; d = 2; s = 1; end
            4'h5: begin q = 2; d = 1; s = 1; end
            4'h6: begin q = 6; d = 3; s = 2; end
            4'h9: begin q = 8; d = 4; s = 2; end
            default: begin q = 4; d = 2; s = 1; end
        endcase
        return nch == 4 ? q : (nch == 2 ? d : s);
    endfunction

    function automatic lsp_frm_s build(input lsp_pkg::lsp_mode_t m,
                                       input lsp_pkg::lsp_chan_e ch);
        lsp_frm_s    f;
        logic [11:0] z [4][4];
        int          nch, nl, c, k;
        nch = ch == lsp_pkg::LSP_QUAD ? 4 : (ch == lsp_pkg::LSP_DUAL ? 2 : 1);
        nl = lanes(m, nch);
        for (int i = 0; i < 16; i++) begin
            z[i/4][i%4] = (i / 4 < nch) ? smp[i/4][i%4] : 12'h000;
        end
        f = '0;
        f.en = 8'((1 << nl) - 1);
        case (m)
            4'h3: f.bits = 6'h28;
            4'h7, 4'h9: f.bits = 6'h08;
            4'h8: f.bits = 6'h18;
            default: f.bits = 6'h10;
        endcase
        for (int l = 0; l < nl; l++) begin
            c = (m == 4'h6) ? l / 3 * 2 : 0;
            k = (m == 4'h6) ? l % 3 : l;
            case (m)
                4'h3: f.word[l] = {z[l][0][9:0], z[l][1][9:0],
                                   z[l][2][9:0], z[l][3][9:0]};
                4'h4, 4'h6: begin
                    if (m == 4'h4 && k == 0)
                        f.word[l] = {z[0][0], z[1][0][11:8], 24'h0};
                    else if (m == 4'h4 && k == 1)
                        f.word[l] = {z[1][0][7:0], z[2][0][11:4], 24'h0};
                    else if (m == 4'h4)
                        f.word[l] = {z[2][0][3:0], z[3][0], 24'h0};
                    else if (k == 0)
                        f.word[l] = {z[c][0], z[c][1][11:8], 24'h0};
                    else if (k == 1)
                        f.word[l] = {z[c][1][7:0], z[c+1][0][11:4], 24'h0};
                    else
                        f.word[l] = {z[c+1][0][3:0], z[c+1][1], 24'h0};
                end
                4'h5: f.word[l] = {z[2*l][0][7:0], z[2*l+1][0][7:0], 24'h0};
                4'h7: f.word[l] = {z[l][0][7:0], 32'h0};
                4'h8: f.word[l] = {z[l][0], z[l][1], 16'h0};
                default: f.word[l] = {z[l/2][l%2][7:0], 32'h0};
            endcase
        end
        return f;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Leaves samp_valid high so frames can follow back to back
    task automatic send(input int depth);
        logic [11:0] msk;
        msk = (mode == 4'h3) ? 12'h3FF : ((mode == 4'h5 || mode == 4'h7 ||
              mode == 4'h9) ? 12'h0FF : 12'hFFF);
        base++;
        for (int n = 0; n < depth; n++) begin
            for (int c = 0; c < 4; c++) begin
                smp[c][n] = 12'(base * 419 + c * 1129 + n * 2311) & msk;
                samp_in[c] = smp[c][n];
            end
            samp_valid = 1'b1;
            step(1);
        end
    endtask

    task automatic frame(input lsp_pkg::lsp_mode_t m,
                         input lsp_pkg::lsp_chan_e ch);
        if (mode !== m || chans !== ch) begin
            mode = m;
            chans = ch;
            step(3);
        end
        send(m == 4'h3 ? 4 : ((m == 4'h6 || m > 4'h7) ? 2 : 1));
        samp_valid = 1'b0;
        exp_q.push_back(build(m, ch));
    endtask

    task automatic collect(input int k);
        int t;
        t = 0;
        while (rx.frames.size() < k && t < 40) begin
            step(1);
            t++;
        end
        if (rx.frames.size() < k) begin
            n_fail++;
            $display("ERROR t=%0t frame missing", $time);
            report_and_stop();
        end
        repeat (k) chk(rx.frames.pop_front(), exp_q.pop_front());
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_mode(input lsp_pkg::lsp_mode_t m);
        for (int i = 0; i < 3; i++) begin
            frame(m, lsp_pkg::lsp_chan_e'(i));
            collect(1);
        end
        $display("test mode %0d done", m);
    endtask

    task automatic t_latency();
        int cnt;
        cnt = 0;
        frame(4'h8, lsp_pkg::LSP_QUAD);
        while (out_valid !== 1'b1 && cnt < 10) begin
            @(posedge core_clk);
            #1;
            cnt++;
        end
        // Counted from the edge that took the last sample
        chk(334'(cnt), 334'd1);
        step(1);
        chk(334'(out_valid), 334'd0);
        collect(1);
        $display("test latency done");
    endtask

    task automatic t_b2b();
        mode = 4'h7;
        chans = lsp_pkg::LSP_QUAD;
        step(3);
        repeat (3) begin
            send(1);
            exp_q.push_back(build(4'h7, lsp_pkg::LSP_QUAD));
        end
        samp_valid = 1'b0;
        collect(3);
        $display("test back to back done");
    endtask

    task automatic t_refuse();
        frame(4'h3, lsp_pkg::LSP_DUAL);
        collect(1);
        mode = 4'h3;
        send(2);
        samp_valid = 1'b0;
        chans = lsp_pkg::LSP_QUAD;
        step(3);
        frame(4'h3, lsp_pkg::LSP_QUAD);
        collect(1);
        mode = 4'h2;
        step(3);
        send(4);
        samp_valid = 1'b0;
        sys_rst = 1'b1;
        step(2);
        chk({out_valid, lane_en, lane_bits, lane_word[0]}, '0);
        sys_rst = 1'b0;
        step(10);
        chk(334'(rx.frames.size()), 334'd0);
        $display("test refusal done");
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        step(10);
        chk(334'(out_valid), 334'd0);
        chk({lane_en, lane_bits, lane_word}, '0);
        sys_rst = 1'b0;
        step(2);
        t_latency();
        t_mode(4'h3);
        t_mode(4'h4);
        t_mode(4'h5);
        t_mode(4'h6);
        t_mode(4'h7);
        t_mode(4'h8);
        t_mode(4'h9);
        t_b2b();
        t_refuse();
        report_and_stop();
    end
endmodule // lane_sample_packer_tb_top
